// File: src/acr_config_regs.sv
// configuration registers 1..3 of the converter and their decoded controls
`timescale 1ns/100ps

// Summary of operation
// - rate field picks output data rate
// - rate codes scale by operating mode
// - rates scale with the device clock
// - mode field: normal, duty, turbo
// - bit 2 selects continuous conversions
// - temperature mode forces internal reference
// - bit 0 enables burn-out current sources
// - reference field selects reference source
// - filter field selects line rejection
// - filter only at slowest normal/duty rate
// - switch closes on start, opens on sleep
// - current field sets both excitation sources
// - all registers reset to zero
// - registers written any time by commands
// - sleep keeps register contents
// - ready also on shared pin if set
module acr_config_regs #(
  parameter int unsigned MOD_DIV = acr_pkg::MOD_DIV
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_reg_wr_en, // register_write_command, one byte
  input wire logic i_reg_rd_en, // register_read_command, one byte
  input wire logic [1:0] i_reg_addr, // register offset
  input wire logic [7:0] i_reg_wdata, // byte to write
  input wire logic i_start_command, // begin-conversion command
  input wire logic i_sleep_command, // sleep_command
  input wire logic i_data_read, // host has read the result
  output logic [7:0] o_reg_rdata, // read byte
  output logic o_reg_rvalid, // read byte valid, one cycle
  output logic [2:0] o_output_rate_select,
  output logic [1:0] o_op_mode,
  output logic o_continuous_conversion_select,
  output logic o_temperature_measure_enable,
  output logic o_burnout_source_enable,
  output logic [1:0] o_reference_select, // effective source
  output logic [1:0] o_line_filter_select, // effective filter
  output logic o_low_side_switch_closed,
  output logic [2:0] o_excitation_current_level,
  output logic [2:0] o_first_current_route,
  output logic [2:0] o_second_current_route,
  output logic o_converting, // conversion in progress
  output logic o_result_ready_n, // result_ready_pin, active low
  output logic o_shared_output_ready_n // shared_output_ready_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rate_cfg; // rate_and_conversion_config
    logic [7:0] ref_cfg; // reference_filter_current_config
    logic [7:0] route_cfg; // current_routing_ready_config
    logic [7:0] rdata; // read answer
    logic rvalid; // read answer strobe
    logic [1:0] ref_eff; // reference after temperature override
    logic [1:0] filt_eff; // filter after rate gating
    logic sw_closed; // low-side switch state
    logic start_p; // start pulse to pacer
    logic stop_p; // stop pulse to pacer
    logic ready_n; // dedicated ready pin
    logic shared_n; // shared ready pin
  } acr_regs_t;

  acr_regs_t regs_r;
  acr_regs_t regs_nxt;
  logic [2:0] rate_code; // rate field of the next value
  logic [1:0] mode_code; // mode field of the next value

  // bundles the pacer controls; only this bank drives the requests
  acr_pace_if pace ();

  // ----------------------------------------------------------------
  // conversion pacer
  // ----------------------------------------------------------------
  acr_pacer #(.MOD_DIV(MOD_DIV)) u_pacer (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .pace(pace)
  );

  // fields go to the pacer live, so a new rate applies to the period in progress
  // a change of mode mid-conversion takes effect on the next tick
  assign pace.rate = regs_r.rate_cfg[acr_pkg::RATE_LSB +: 3];
  assign pace.mode = regs_r.rate_cfg[acr_pkg::MODE_LSB +: 2];
  assign pace.cont = regs_r.rate_cfg[acr_pkg::CONT_BIT];
  assign pace.start = regs_r.start_p;
  assign pace.stop = regs_r.stop_p;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    regs_nxt = regs_r;
    regs_nxt.rvalid = 1'b0;
    regs_nxt.start_p = i_start_command;
    regs_nxt.stop_p = i_sleep_command & ~i_start_command;
    if (i_reg_wr_en) begin
      unique case (i_reg_addr)
        acr_pkg::ADDR_RATE: regs_nxt.rate_cfg = i_reg_wdata;
        acr_pkg::ADDR_REF: regs_nxt.ref_cfg = i_reg_wdata;
        acr_pkg::ADDR_ROUTE: regs_nxt.route_cfg = i_reg_wdata;
        default: ; // offset 0 lives elsewhere
      endcase
    end
    // a read and a write in one cycle return the old byte
    // read returns stored byte
    if (i_reg_rd_en) begin
      regs_nxt.rvalid = 1'b1;
      unique case (i_reg_addr)
        acr_pkg::ADDR_RATE: regs_nxt.rdata = regs_r.rate_cfg;
        acr_pkg::ADDR_REF: regs_nxt.rdata = regs_r.ref_cfg;
        acr_pkg::ADDR_ROUTE: regs_nxt.rdata = regs_r.route_cfg;
        default: regs_nxt.rdata = acr_pkg::CFG_RST;
      endcase
    end
    // derived controls use the next bytes so they land with the write
    rate_code = regs_nxt.rate_cfg[acr_pkg::RATE_LSB +: 3];
    mode_code = regs_nxt.rate_cfg[acr_pkg::MODE_LSB +: 2];
    if (regs_nxt.rate_cfg[acr_pkg::TEMP_BIT]) begin
      regs_nxt.ref_eff = acr_pkg::VREF_INTERNAL;
    end else begin
      regs_nxt.ref_eff = regs_nxt.ref_cfg[acr_pkg::VREF_LSB +: 2];
    end
    if (rate_code == acr_pkg::RATE_SLOWEST &&
        (mode_code == acr_pkg::MODE_NORMAL ||
         mode_code == acr_pkg::MODE_DUTY)) begin
      regs_nxt.filt_eff = regs_nxt.ref_cfg[acr_pkg::FILT_LSB +: 2];
    end else begin
      regs_nxt.filt_eff = acr_pkg::FILT_NONE;
    end
    // switch follows commands
    // sleep is tested first so it opens the switch even with a start
    if (!regs_nxt.ref_cfg[acr_pkg::PSW_BIT] || i_sleep_command) begin
      regs_nxt.sw_closed = 1'b0;
    end else if (i_start_command) begin
      regs_nxt.sw_closed = 1'b1;
    end
    // a new result wins over a read or start in the same cycle
    if (pace.done) begin
      regs_nxt.ready_n = 1'b0;
    end else if (i_data_read || i_start_command) begin
      regs_nxt.ready_n = acr_pkg::PIN_IDLE;
    end
    if (regs_nxt.route_cfg[acr_pkg::SHRDY_BIT]) begin
      regs_nxt.shared_n = regs_nxt.ready_n;
    end else begin
      regs_nxt.shared_n = acr_pkg::PIN_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // one flop bank holds the whole state, cleared asynchronously
  // sleep never touches the stored bytes
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      regs_r <= '{
        rate_cfg: acr_pkg::CFG_RST,
        ref_cfg: acr_pkg::CFG_RST,
        route_cfg: acr_pkg::CFG_RST,
        rdata: acr_pkg::CFG_RST,
        rvalid: 1'b0,
        ref_eff: acr_pkg::VREF_INTERNAL,
        filt_eff: acr_pkg::FILT_NONE,
        sw_closed: 1'b0,
        start_p: 1'b0,
        stop_p: 1'b0,
        ready_n: acr_pkg::PIN_IDLE,
        shared_n: acr_pkg::PIN_IDLE
      };
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every output is a register slice, so pins never glitch on a write
  assign o_reg_rdata = regs_r.rdata;
  assign o_reg_rvalid = regs_r.rvalid;
  assign o_output_rate_select = regs_r.rate_cfg[acr_pkg::RATE_LSB +: 3];
  assign o_op_mode = regs_r.rate_cfg[acr_pkg::MODE_LSB +: 2];
  assign o_continuous_conversion_select =
    regs_r.rate_cfg[acr_pkg::CONT_BIT];
  assign o_temperature_measure_enable = regs_r.rate_cfg[acr_pkg::TEMP_BIT];
  assign o_burnout_source_enable = regs_r.rate_cfg[acr_pkg::BURN_BIT];
  assign o_reference_select = regs_r.ref_eff;
  assign o_line_filter_select = regs_r.filt_eff;
  assign o_low_side_switch_closed = regs_r.sw_closed;
  assign o_excitation_current_level =
    regs_r.ref_cfg[acr_pkg::EXCITATION_CURRENT_LEVEL_LSB +: 3];
  assign o_first_current_route = regs_r.route_cfg[acr_pkg::ROUTE1_LSB +: 3];
  assign o_second_current_route =
    regs_r.route_cfg[acr_pkg::ROUTE2_LSB +: 3];
  assign o_converting = pace.busy;
  assign o_result_ready_n = regs_r.ready_n;
  assign o_shared_output_ready_n = regs_r.shared_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  // ----------------------------------------------------------------
  // read-back reference
  // ----------------------------------------------------------------
  // last byte written to the reference register, kept apart from the
  // bank so the read-back check does not trust the storage it checks
  logic [7:0] ref_shadow_r;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_shadow_r <= acr_pkg::CFG_RST;
    end else if (i_reg_wr_en && i_reg_addr == acr_pkg::ADDR_REF) begin
      ref_shadow_r <= i_reg_wdata;
    end
  end

  a_write_read_back: assert property (
    i_reg_rd_en && i_reg_addr == acr_pkg::ADDR_REF |=>
    o_reg_rvalid && o_reg_rdata == $past(ref_shadow_r))
    else $error("read did not return last written byte");
  a_reset_zero: assert property (
    $rose(i_rstn) |-> regs_r.rate_cfg == acr_pkg::CFG_RST &&
    regs_r.ref_cfg == acr_pkg::CFG_RST &&
    regs_r.route_cfg == acr_pkg::CFG_RST)
    else $error("register not zero after reset");
  a_temp_ref_int: assert property (
    o_temperature_measure_enable |->
    o_reference_select == acr_pkg::VREF_INTERNAL)
    else $error("temperature mode not on internal reference");
  a_filter_gating: assert property (
    o_output_rate_select != acr_pkg::RATE_SLOWEST |->
    o_line_filter_select == acr_pkg::FILT_NONE)
    else $error("line filter active at a fast rate");
  a_switch_sleep_open: assert property (
    i_sleep_command |=> !o_low_side_switch_closed)
    else $error("switch not open after sleep");
  a_switch_start_close: assert property (
    i_start_command && !i_sleep_command &&
    regs_nxt.ref_cfg[acr_pkg::PSW_BIT] |=> o_low_side_switch_closed)
    else $error("switch not closed after start");
  a_shared_quiet: assert property (
    !regs_r.route_cfg[acr_pkg::SHRDY_BIT] |-> o_shared_output_ready_n)
    else $error("shared pin signalled ready while disabled");
  a_sleep_keeps: assert property (
    i_sleep_command && !i_reg_wr_en |=>
    regs_r.rate_cfg == $past(regs_r.rate_cfg) &&
    regs_r.ref_cfg == $past(regs_r.ref_cfg))
    else $error("sleep altered configuration");
  a_ready_on_done: assert property (
    pace.done |=> !o_result_ready_n)
    else $error("ready pin missed a result");

  // write checks compare against the bus byte, not the stored copy
  a_rate_write: assert property (
    i_reg_wr_en && i_reg_addr == acr_pkg::ADDR_RATE |=>
    {o_output_rate_select, o_op_mode, o_continuous_conversion_select,
     o_temperature_measure_enable, o_burnout_source_enable} ==
    $past(i_reg_wdata))
    else $error("rate register outputs differ from written byte");
  a_level_write: assert property (
    i_reg_wr_en && i_reg_addr == acr_pkg::ADDR_REF |=>
    o_excitation_current_level == $past(i_reg_wdata[2:0]))
    else $error("excitation level differs from written field");
  a_route_write: assert property (
    i_reg_wr_en && i_reg_addr == acr_pkg::ADDR_ROUTE |=>
    {o_first_current_route, o_second_current_route} ==
    $past(i_reg_wdata[7:2]))
    else $error("current routes differ from written fields");
  a_shared_mirror: assert property (
    regs_r.route_cfg[acr_pkg::SHRDY_BIT] |->
    o_shared_output_ready_n == o_result_ready_n)
    else $error("shared pin does not follow the ready pin");
  a_ready_release: assert property (
    i_data_read && !pace.done |=> o_result_ready_n)
    else $error("ready pin not released after result read");

  // covers mark the main scenarios as reached
  c_cont_run: cover property (
    pace.done && o_continuous_conversion_select);
  c_shared_ready: cover property (!o_shared_output_ready_n);
  c_filter_live: cover property (
    o_line_filter_select != acr_pkg::FILT_NONE);

endmodule : acr_config_regs

// File: src/acr_pace_if.sv
// link between the register bank and the conversion pacer
`timescale 1ns/100ps
interface acr_pace_if;
  logic [2:0] rate; // rate code
  logic [1:0] mode; // operating mode code
  logic cont; // continuous conversions
  logic start; // begin-conversion pulse
  logic stop; // sleep pulse
  logic busy; // conversion in progress
  logic done; // one-cycle end of conversion

  modport ctl (output rate, mode, cont, start, stop, input busy, done);
  modport pacer (input rate, mode, cont, start, stop, output busy, done);
endinterface : acr_pace_if

// File: src/acr_pacer.sv
// conversion pacer: paces end-of-conversion events at the selected rate
`timescale 1ns/100ps
module acr_pacer #(
  parameter int unsigned MOD_DIV = acr_pkg::MOD_DIV
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  acr_pace_if.pacer pace
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    acr_pkg::acr_pace_st_t st; // idle or running
    logic [15:0] div; // system clocks within a turbo tick
    logic half; // halves turbo ticks for normal rate
    logic [15:0] per; // modulator ticks within a conversion
    logic done; // end-of-conversion pulse
  } acr_pace_t;

  acr_pace_t pace_r;
  acr_pace_t pace_nxt;
  logic turbo_tick; // one-cycle enable at the turbo rate
  logic mod_tick; // modulator clock enable for the mode
  logic code_ok; // rate and mode codes are not reserved
  logic [15:0] target; // ticks per conversion

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    pace_nxt = pace_r;
    pace_nxt.done = 1'b0;
    // divider from clock
    // dividing the device clock keeps every rate proportional to it
    turbo_tick = (pace_r.div == 16'(MOD_DIV - 1));
    mod_tick = turbo_tick &
      ((pace.mode == acr_pkg::MODE_TURBO) | pace_r.half);
    // reserved codes stall the pacer: no result is ever produced
    code_ok = (pace.rate != acr_pkg::RATE_RSVD) &&
      (pace.mode != acr_pkg::MODE_RSVD);
    target = acr_pkg::RATE_TICKS[pace.rate];
    if (pace.mode == acr_pkg::MODE_DUTY) begin
      target = target << acr_pkg::DUTY_SHIFT;
    end
    unique case (pace_r.st)
      acr_pkg::PACE_IDLE: begin
        pace_nxt.div = '0;
        pace_nxt.half = 1'b0;
        pace_nxt.per = '0;
      end
      acr_pkg::PACE_RUN: begin
        pace_nxt.div = turbo_tick ? '0 : pace_r.div + 16'h0001;
        if (turbo_tick) begin
          pace_nxt.half = ~pace_r.half;
        end
        if (mod_tick && code_ok) begin
          if (pace_r.per >= target - 16'h0001) begin
            pace_nxt.per = '0;
            pace_nxt.done = 1'b1;
            if (!pace.cont) begin
              pace_nxt.st = acr_pkg::PACE_IDLE;
            end
          end else begin
            pace_nxt.per = pace_r.per + 16'h0001;
          end
        end
      end
    endcase
    // a fresh start restarts the period, sleep wins over nothing
    if (pace.start) begin
      pace_nxt.st = acr_pkg::PACE_RUN;
      pace_nxt.div = '0;
      pace_nxt.half = 1'b0;
      pace_nxt.per = '0;
    end else if (pace.stop) begin
      pace_nxt.st = acr_pkg::PACE_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pace_r <= '{acr_pkg::PACE_IDLE, 16'h0000, 1'b0, 16'h0000, 1'b0};
    end else begin
      pace_r <= pace_nxt;
    end
  end

  assign pace.busy = (pace_r.st == acr_pkg::PACE_RUN);
  assign pace.done = pace_r.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_single_shot_stop: assert property (
    pace.done && !pace.cont && !pace.start |-> !pace.busy)
    else $error("single-shot conversion kept running");
  a_done_one_cycle: assert property (
    pace.done |=> !pace.done)
    else $error("end of conversion longer than one cycle");
  a_reserved_stall: assert property (
    pace.rate == acr_pkg::RATE_RSVD |=> !pace.done)
    else $error("reserved rate produced a result");

  c_single_done: cover property (pace.done && !pace.cont);
  c_cont_done: cover property (pace.done && pace.cont);

endmodule : acr_pacer

// File: src/acr_pkg.sv
// constants shared by the configuration register bank and its pacer
package acr_pkg;

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_RATE = 2'h1; // rate_and_conversion_config
  localparam logic [1:0] ADDR_REF = 2'h2; // reference_filter_current_config
  localparam logic [1:0] ADDR_ROUTE = 2'h3; // current_routing_ready_config
  localparam logic [7:0] CFG_RST = 8'h00; // every register clears to zero
  localparam logic PIN_IDLE = 1'b1; // ready pins idle high

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RATE_LSB = 5; // output_rate_select [7:5]
  localparam int MODE_LSB = 3; // operating mode [4:3]
  localparam int CONT_BIT = 2; // continuous_conversion_select
  localparam int TEMP_BIT = 1; // temperature_measure_enable
  localparam int BURN_BIT = 0; // burnout_source_enable
  localparam int VREF_LSB = 6; // reference source [7:6]
  localparam int FILT_LSB = 4; // line filter [5:4]
  localparam int PSW_BIT = 3; // low_side_switch_auto
  localparam int EXCITATION_CURRENT_LEVEL_LSB = 0; // excitation_current_level [2:0]
  localparam int ROUTE1_LSB = 5; // first_current_route [7:5]
  localparam int ROUTE2_LSB = 2; // second_current_route [4:2]
  localparam int SHRDY_BIT = 1; // ready_on_shared_pin

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_DUTY = 2'h1;
  localparam logic [1:0] MODE_TURBO = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [2:0] RATE_SLOWEST = 3'h0;
  localparam logic [2:0] RATE_RSVD = 3'h7;
  localparam logic [1:0] VREF_INTERNAL = 2'h0;
  localparam logic [1:0] FILT_NONE = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 32'h0BEB_C200; // 200 MHz
  localparam int unsigned TURBO_MOD_HZ = 32'h0007_D000; // 512 kHz
  // system clocks per turbo modulator tick, rounded down
  localparam int unsigned MOD_DIV = CLK_HZ / TURBO_MOD_HZ;
  localparam int DUTY_SHIFT = 2; // duty-cycle mode runs 1:4
  // normal-mode modulator ticks per conversion, per rate code
  localparam logic [15:0] RATE_TICKS [0:7] = '{
    16'h3200, 16'h1639, 16'h0B1C, 16'h05B7,
    16'h0308, 16'h01AB, 16'h0100, 16'h0000
  };

  // pacer states
  typedef enum logic [0:0] {PACE_IDLE, PACE_RUN} acr_pace_st_t;

endpackage : acr_pkg

// File: verification/acr_host_model.sv
// host controller model issuing register and command strobes
`timescale 1ns/100ps
module acr_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic o_reg_wr_en,
  output logic o_reg_rd_en,
  output logic [1:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_start_command,
  output logic o_sleep_command,
  output logic o_data_read
);
  // ----------------------------------------------------------------
  // idle levels, applied by the bench at time zero
  // ----------------------------------------------------------------
  task automatic idle();
    o_reg_wr_en = 1'b0;
    o_reg_rd_en = 1'b0;
    o_reg_addr = 2'h0;
    o_reg_wdata = 8'h00;
    o_start_command = 1'b0;
    o_sleep_command = 1'b0;
    o_data_read = 1'b0;
  endtask : idle

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_reg_addr = a;
    o_reg_wdata = (a == 2'h3) ? (d & 8'hFE) : d;
    o_reg_wr_en = 1'b1;
    @(negedge i_clock);
    o_reg_wr_en = 1'b0;
    // released data shows the inverse, so a stale copy cannot pass
    o_reg_wdata = ~o_reg_wdata;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] d,
                    output logic ok);
    @(negedge i_clock);
    o_reg_addr = a;
    o_reg_rd_en = 1'b1;
    @(negedge i_clock);
    o_reg_rd_en = 1'b0;
    ok = (i_reg_rvalid === 1'b1);
    d = i_reg_rdata;
  endtask : rd

  // one-cycle command: 0 start, 1 sleep, 2 result read
  task automatic pulse(input int k);
    @(negedge i_clock);
    o_start_command = (k == 0);
    o_sleep_command = (k == 1);
    o_data_read = (k == 2);
    @(negedge i_clock);
    o_start_command = 1'b0;
    o_sleep_command = 1'b0;
    o_data_read = 1'b0;
  endtask : pulse
endmodule : acr_host_model

// File: verification/tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/100ps
module tb;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic wr_en, rd_en, start_c, sleep_c, data_rd;
  logic [1:0] addr;
  logic [7:0] wdata, rdata;
  logic rvalid, cont, temp, burn, sw, conv, rdy_n, shr_n;
  logic [2:0] rate, excitation_current_level, route1, route2;
  logic [1:0] mode, vref, filt;
  int bad_count = 0;
  int cmp_count = 0;
  logic [7:0] p;
  int n;
  logic [7:0] cfg [0:2] = '{8'hC0, 8'hC8, 8'hD0}; // normal, duty, turbo
  int clk_exp [0:2] = '{1024, 4096, 512}; // 256 ticks, MOD_DIV 2

  always #2.5 i_clock = ~i_clock;

  acr_config_regs #(.MOD_DIV(2)) acr_config_regs_inst (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_reg_wr_en(wr_en),
    .i_reg_rd_en(rd_en), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_start_command(start_c), .i_sleep_command(sleep_c),
    .i_data_read(data_rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .o_output_rate_select(rate), .o_op_mode(mode),
    .o_continuous_conversion_select(cont),
    .o_temperature_measure_enable(temp), .o_burnout_source_enable(burn),
    .o_reference_select(vref), .o_line_filter_select(filt),
    .o_low_side_switch_closed(sw), .o_excitation_current_level(excitation_current_level),
    .o_first_current_route(route1), .o_second_current_route(route2),
    .o_converting(conv), .o_result_ready_n(rdy_n),
    .o_shared_output_ready_n(shr_n));

  acr_host_model acr_host_model_inst (
    .i_clock(i_clock), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
    .o_reg_wr_en(wr_en), .o_reg_rd_en(rd_en), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_start_command(start_c),
    .o_sleep_command(sleep_c), .o_data_read(data_rd));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    acr_host_model_inst.rd(a, d, ok);
    chk({15'h0, ok}, 16'h0001);
    chk({8'h0, d}, {8'h0, exp});
  endtask : rdchk

  // let derived registered outputs settle
  task automatic step();
    repeat (2) @(negedge i_clock);
  endtask : step

  // bounded wait for the ready pin; a timeout ends the run
  task automatic wait_rdy(output int cnt);
    cnt = 0;
    while (rdy_n !== 1'b0) begin
      @(negedge i_clock);
      cnt++;
      if (cnt > 6000) begin
        bad_count++;
        end_sim();
      end
    end
  endtask : wait_rdy

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    acr_host_model_inst.idle();
    repeat (16) @(posedge i_clock);
    @(negedge i_clock);
    i_rstn = 1'b1;
    for (int a = 1; a < 4; a++) rdchk(a[1:0], 8'h00);
    chk({vref, filt, sw, conv, rdy_n, shr_n}, 16'h0003);
    $display("test reset done");
    // storage, field mapping and reserved codes
    foreach (cfg[i]) begin
      p = 8'hA5 ^ (8'h5A << i);
      for (int a = 1; a < 4; a++) begin
        acr_host_model_inst.wr(a[1:0], p);
        step();
        rdchk(a[1:0], (a == 3) ? (p & 8'hFE) : p);
      end
      chk({8'h0, rate, mode, cont, temp, burn}, {8'h0, p & 8'hFF});
      chk({13'h0, excitation_current_level}, {13'h0, p[2:0]});
      chk({10'h0, route1, route2}, {10'h0, p[7:2]});
    end
    acr_host_model_inst.wr(2'h1, 8'hFF);
    rdchk(2'h1, 8'hFF);
    rdchk(2'h0, 8'h00);
    $display("test storage done");
    // reference select and temperature override
    for (int v = 0; v < 4; v++) begin
      acr_host_model_inst.wr(2'h1, 8'h00);
      acr_host_model_inst.wr(2'h2, {v[1:0], 6'h00});
      step();
      chk({14'h0, vref}, v[15:0]);
      acr_host_model_inst.wr(2'h1, 8'h02);
      step();
      chk({14'h0, vref}, 16'h0000);
    end
    $display("test reference done");
    // line filter only at the slowest normal or duty rate
    for (int f = 1; f < 4; f++) begin
      for (int m = 0; m < 4; m++) begin
        for (int r = 0; r < 2; r++) begin
          acr_host_model_inst.wr(2'h2, {2'h0, f[1:0], 4'h0});
          acr_host_model_inst.wr(2'h1, {r[2:0], m[1:0], 3'h0});
          step();
          chk({14'h0, filt}, (r == 0 && m < 2) ? f[15:0] : 16'h0);
        end
      end
    end
    $display("test filter done");
    // low-side switch follows start and sleep
    acr_host_model_inst.wr(2'h2, 8'h08);
    acr_host_model_inst.pulse(0);
    step();
    chk({15'h0, sw}, 16'h0001);
    acr_host_model_inst.pulse(1);
    step();
    chk({15'h0, sw}, 16'h0000);
    rdchk(2'h2, 8'h08);
    acr_host_model_inst.wr(2'h2, 8'h00);
    acr_host_model_inst.pulse(0);
    step();
    chk({15'h0, sw}, 16'h0000);
    acr_host_model_inst.pulse(1);
    $display("test switch done");
    // single-shot period per mode, ready on both pins
    acr_host_model_inst.wr(2'h3, 8'h02);
    foreach (cfg[i]) begin
      acr_host_model_inst.wr(2'h1, cfg[i]);
      acr_host_model_inst.pulse(0);
      wait_rdy(n);
      chk({15'h0, n >= clk_exp[i] - 4 && n <= clk_exp[i] + 8}, 16'h1);
      chk({14'h0, shr_n, conv}, 16'h0000);
      acr_host_model_inst.pulse(2);
      step();
      chk({14'h0, rdy_n, shr_n}, 16'h0003);
    end
    $display("test rates done");
    // continuous run, shared pin disabled, then sleep
    acr_host_model_inst.wr(2'h3, 8'h00);
    acr_host_model_inst.wr(2'h1, 8'hC4);
    acr_host_model_inst.pulse(0);
    wait_rdy(n);
    chk({14'h0, shr_n, conv}, 16'h0003);
    acr_host_model_inst.pulse(2);
    acr_host_model_inst.pulse(1);
    step();
    chk({15'h0, conv}, 16'h0000);
    rdchk(2'h1, 8'hC4);
    $display("test continuous done");
    // mid-run reset clears every register again
    @(negedge i_clock);
    i_rstn = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rstn = 1'b1;
    for (int a = 1; a < 4; a++) rdchk(a[1:0], 8'h00);
    chk({14'h0, conv, rdy_n}, 16'h0001);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : tb
